// *** logic/ddrap_defines.svh ***
// constants for the read auto-precharge link: latencies, burst, timing, geometry
// assumes a single 20 MHz clock; every time is in picoseconds
`ifndef DDRAP_DEFINES_SVH
`define DDRAP_DEFINES_SVH

// ***************************************************************
// mode settings
// ***************************************************************
`define DDRAP_AL 1
`define DDRAP_CL 3
`define DDRAP_BL 4

// ***************************************************************
// timing in picoseconds
// ***************************************************************
`define DDRAP_TCK_PS 50000
`define DDRAP_TRAS_PS 40000
`define DDRAP_TRTP_PS 7500
`define DDRAP_TRP_PS 15000

// ***************************************************************
// fixed clock spacings
// ***************************************************************
`define DDRAP_PREFETCH_GAP 2
`define DDRAP_MIN_RTP_CK 2
`define DDRAP_WR_EXTRA 2

// ***************************************************************
// geometry
// ***************************************************************
`define DDRAP_NBANK 8
`define DDRAP_BA_W 3
`define DDRAP_DQ_W 16
`define DDRAP_FIFO_DEPTH 16
`define DDRAP_CNT_W 8

`endif

// *** logic/ddrap_pkg.sv ***
// types shared by both ends of the read auto-precharge link
// assumes nothing beyond a SystemVerilog compiler
package ddrap_pkg;

  // ***************************************************************
  // command encoding on the link
  // ***************************************************************
  typedef enum logic [2:0] {
    DDRAP_NOP,
    DDRAP_ACT,
    DDRAP_RD,
    DDRAP_WR,
    DDRAP_PRE
  } ddrap_cmd_t;

endpackage : ddrap_pkg

// *** logic/ddrap_if.sv ***
// link between the memory controller end and the device end
// assumes both ends run on the same clock; only the device end drives the data wires
`timescale 1ns/1ps
`include "ddrap_defines.svh"

interface ddrap_if;

  ddrap_pkg::ddrap_cmd_t cmd; // command, one per clock
  logic [`DDRAP_BA_W-1:0] ba; // bank address
  logic a10; // auto-precharge select on a read
  logic [`DDRAP_DQ_W-1:0] dq_rise; // element on the rising half
  logic [`DDRAP_DQ_W-1:0] dq_fall; // element on the falling half
  logic dq_oe_n; // low while the device drives data
  logic ldqs; // lower strobe, bits 7..0
  logic ldqs_oe_n; // low while lower strobe driven
  logic udqs; // upper strobe, bits 15..8
  logic udqs_oe_n; // low while upper strobe driven

  modport dev (
    input cmd, ba, a10,
    output dq_rise, dq_fall, dq_oe_n, ldqs, ldqs_oe_n, udqs, udqs_oe_n
  );

  modport ctl (
    output cmd, ba, a10,
    input dq_rise, dq_fall, dq_oe_n, ldqs, ldqs_oe_n, udqs, udqs_oe_n
  );

endinterface : ddrap_if

// *** logic/ddrap_dev.sv ***
// device end: per-bank auto-precharge scheduling and read data return
// assumes commands arrive registered from the controller on clk; read data
// is supplied from the user side through a 16-word fifo
//
// Operation
// - a10 high on read selects auto precharge
// - read without a10 leaves row open
// - precharge at al plus bl/2 edge
// - postpone precharge until tras met
// - postpone precharge until trtp met
// - trp counted from actual precharge start
// - controller waits al+bl/2-2+(trtp+trp)/tck before activate, or the close edge plus trp when that is longer
// - controller rounds (trtp+trp)/tck up
// - precharge not before two clocks after prefetch
// - other banks accept commands during auto precharge
// - controller spaces reads bl/2 clocks apart after a read with auto precharge
// - write after bl/2+2, pre/act after one
// - controller precharges only after tras met
// - lower strobe low byte, upper strobe high
// - first data after al plus cl
`timescale 1ns/1ps
`include "ddrap_defines.svh"

// ***************************************************************
// fifo in the read data path
// ***************************************************************
module ddrap_fifo #(
  parameter int W = 32,
  parameter int DEPTH = `DDRAP_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH]; // storage, no reset needed
  logic [AW:0] wr_ptr_ff; // extra bit tells full from empty
  logic [AW:0] rd_ptr_ff;
  logic push;
  logic pop;

  assign out_valid = (wr_ptr_ff != rd_ptr_ff);
  assign in_ready = (wr_ptr_ff[AW-1:0] != rd_ptr_ff[AW-1:0]) || (wr_ptr_ff[AW] == rd_ptr_ff[AW]);
  assign push = ce && in_valid && in_ready;
  assign pop = ce && out_valid && out_ready;
  assign out_data = mem[rd_ptr_ff[AW-1:0]];

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
    end
  end
endmodule : ddrap_fifo

// ***************************************************************
// device end
// ***************************************************************
module ddrap_dev #(
  parameter int AL = `DDRAP_AL,
  parameter int CL = `DDRAP_CL,
  parameter int BL = `DDRAP_BL,
  parameter int NBANK = `DDRAP_NBANK
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  ddrap_if.dev link,
  input wire logic [2*`DDRAP_DQ_W-1:0] fill_data,
  input wire logic fill_valid,
  output logic fill_ready,
  output logic [NBANK-1:0] bank_open,
  output logic [NBANK-1:0] bank_prech,
  output logic underrun
);
  localparam int CW = `DDRAP_CNT_W;
  localparam int RL = AL + CL;
  localparam int HALF = BL / 2;
  localparam int TRAS_CK = (`DDRAP_TRAS_PS + `DDRAP_TCK_PS - 1) / `DDRAP_TCK_PS;
  localparam int TRP_CK = (`DDRAP_TRP_PS + `DDRAP_TCK_PS - 1) / `DDRAP_TCK_PS;
  localparam int TRTP_RAW = (`DDRAP_TRTP_PS + `DDRAP_TCK_PS - 1) / `DDRAP_TCK_PS;
  localparam int TRTP_CK = (TRTP_RAW > `DDRAP_MIN_RTP_CK) ? TRTP_RAW : `DDRAP_MIN_RTP_CK;
  // last 4-bit prefetch sits al+bl/2-2 after the read
  localparam int PREF_CK = AL + HALF - `DDRAP_PREFETCH_GAP;
  localparam logic [CW-1:0] SCHED_LD = CW'(AL + HALF - 1);
  localparam logic [CW-1:0] RTP_LD = CW'(PREF_CK + TRTP_CK - 1);
  localparam logic [CW-1:0] RAS_LD = CW'(TRAS_CK - 1);
  localparam logic [CW-1:0] RP_LD = CW'(TRP_CK);
  localparam logic [CW-1:0] BEAT_LD = CW'(HALF - 1);

  logic [2*`DDRAP_DQ_W-1:0] fifo_data; // next pair of elements
  logic fifo_valid;
  logic fifo_pop; // drain side, only during a burst
  logic [RL-1:0] lat_line_ff; // read latency delay line
  logic [CW-1:0] beats_ff; // beats left in the burst
  logic burst_start;
  logic in_burst;
  logic is_read;

  // ***************************************************************
  // per-bank precharge scheduling
  // ***************************************************************
  assign is_read = (link.cmd == ddrap_pkg::DDRAP_RD);

  for (genvar b = 0; b < NBANK; b++) begin : g_bank
    logic hit; // command aimed at this bank only
    logic open_ff; // row open
    logic pend_ff; // auto precharge waiting
    logic [CW-1:0] sched_ff; // to al+bl/2 edge
    logic [CW-1:0] ras_ff; // to tras met
    logic [CW-1:0] rtp_ff; // to trtp met after last prefetch
    logic [CW-1:0] rp_ff; // precharge period running
    logic fire;

    assign hit = ce && (link.ba == `DDRAP_BA_W'(b));
    // all three minimums must read zero before the close starts
    assign fire = pend_ff && (sched_ff == '0) && (ras_ff == '0) && (rtp_ff == '0);
    assign bank_open[b] = open_ff;
    assign bank_prech[b] = (rp_ff != '0);

    // row state and pending close, kept apart for each bank
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        open_ff <= 1'b0;
        pend_ff <= 1'b0;
      end else if (ce) begin
        if (hit && link.cmd == ddrap_pkg::DDRAP_ACT) begin
          open_ff <= 1'b1;
        end else if (hit && link.cmd == ddrap_pkg::DDRAP_PRE) begin
          open_ff <= 1'b0;
        end else if (fire) begin
          open_ff <= 1'b0;
          // a new closing read landing on the firing edge keeps the flag set
          pend_ff <= hit && is_read && link.a10;
        end else if (hit && is_read && link.a10) begin
          pend_ff <= 1'b1;
        end
        // a plain read changes nothing, the row stays open
      end
    end

    // minimum time counters; each reads zero once satisfied
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        sched_ff <= '0;
        ras_ff <= '0;
        rtp_ff <= '0;
      end else if (ce) begin
        if (hit && link.cmd == ddrap_pkg::DDRAP_ACT) begin
          ras_ff <= RAS_LD;
        end else if (ras_ff != '0) begin
          ras_ff <= ras_ff - 1'b1;
        end
        if (hit && is_read && link.a10) begin
          sched_ff <= SCHED_LD;
          rtp_ff <= RTP_LD;
        end else begin
          if (sched_ff != '0) begin
            sched_ff <= sched_ff - 1'b1;
          end
          if (rtp_ff != '0) begin
            rtp_ff <= rtp_ff - 1'b1;
          end
        end
      end
    end

    // precharge period starts at the edge where the close fires,
    // so a late close pushed by trtp shifts trp with it
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        rp_ff <= '0;
      end else if (ce) begin
        if (fire || (hit && link.cmd == ddrap_pkg::DDRAP_PRE)) begin
          rp_ff <= RP_LD;
        end else if (rp_ff != '0) begin
          rp_ff <= rp_ff - 1'b1;
        end
      end
    end
  end

  // ***************************************************************
  // read data return
  // ***************************************************************
  ddrap_fifo #(
    .W(2*`DDRAP_DQ_W),
    .DEPTH(`DDRAP_FIFO_DEPTH)
  ) i_ddrap_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .in_valid(fill_valid),
    .in_ready(fill_ready),
    .in_data(fill_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  assign burst_start = lat_line_ff[RL-1];
  assign in_burst = burst_start || (beats_ff != '0);
  assign fifo_pop = in_burst;

  // latency delay line; a read that reaches the end starts data
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lat_line_ff <= '0;
    end else if (ce) begin
      lat_line_ff <= {lat_line_ff[RL-2:0], is_read};
    end
  end

  // beat counter; back-to-back reads at bl/2 reload seamlessly
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      beats_ff <= '0;
    end else if (ce) begin
      if (burst_start) begin
        beats_ff <= BEAT_LD;
      end else if (beats_ff != '0) begin
        beats_ff <= beats_ff - 1'b1;
      end
    end
  end

  // data and strobes; an empty fifo sends zeros rather than stall the pins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      link.dq_rise <= '0;
      link.dq_fall <= '0;
      link.dq_oe_n <= 1'b1;
      link.ldqs <= 1'b0;
      link.udqs <= 1'b0;
      link.ldqs_oe_n <= 1'b1;
      link.udqs_oe_n <= 1'b1;
      underrun <= 1'b0;
    end else if (ce) begin
      link.dq_rise <= fifo_valid ? fifo_data[`DDRAP_DQ_W-1:0] : '0;
      link.dq_fall <= fifo_valid ? fifo_data[2*`DDRAP_DQ_W-1:`DDRAP_DQ_W] : '0;
      link.dq_oe_n <= !in_burst;
      // each byte lane has its own strobe
      link.ldqs <= in_burst;
      link.udqs <= in_burst;
      link.ldqs_oe_n <= !in_burst;
      link.udqs_oe_n <= !in_burst;
      underrun <= in_burst && !fifo_valid;
    end
  end
endmodule : ddrap_dev

// *** logic/ddrap_ctl.sv ***
// controller end: spaces commands around read with auto precharge
// assumes the device end samples the registered command on the same clock
`timescale 1ns/1ps
`include "ddrap_defines.svh"

module ddrap_ctl #(
  parameter int AL = `DDRAP_AL,
  parameter int BL = `DDRAP_BL,
  parameter int NBANK = `DDRAP_NBANK
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  ddrap_if.ctl link,
  input wire logic req_valid,
  output logic req_ready,
  input wire ddrap_pkg::ddrap_cmd_t req_cmd,
  input wire logic [`DDRAP_BA_W-1:0] req_ba,
  input wire logic req_a10,
  output logic rd_valid,
  output logic [2*`DDRAP_DQ_W-1:0] rd_data
);
  localparam int CW = `DDRAP_CNT_W;
  localparam int HALF = BL / 2;
  localparam int TRAS_CK = (`DDRAP_TRAS_PS + `DDRAP_TCK_PS - 1) / `DDRAP_TCK_PS;
  // sum rounded up as a whole, not term by term
  localparam int RTP_RP_CK = (`DDRAP_TRTP_PS + `DDRAP_TRP_PS + `DDRAP_TCK_PS - 1) / `DDRAP_TCK_PS;
  localparam int TRP_CK = (`DDRAP_TRP_PS + `DDRAP_TCK_PS - 1) / `DDRAP_TCK_PS;
  localparam int TRTP_RAW = (`DDRAP_TRTP_PS + `DDRAP_TCK_PS - 1) / `DDRAP_TCK_PS;
  localparam int TRTP_CK = (TRTP_RAW > `DDRAP_MIN_RTP_CK) ? TRTP_RAW : `DDRAP_MIN_RTP_CK;
  // edge at which the device really starts its close
  localparam int CLOSE_RTP = AL + HALF - `DDRAP_PREFETCH_GAP + TRTP_CK;
  localparam int CLOSE_CK = (CLOSE_RTP > AL + HALF) ? CLOSE_RTP : AL + HALF;
  localparam int AP_ACT_SUM = AL + HALF - `DDRAP_PREFETCH_GAP + RTP_RP_CK;
  // with a slow clock the plain sum undercuts the close plus trp, which
  // would let an activate land before the close; wait for the longer one
  localparam int AP_ACT_CK = (AP_ACT_SUM > CLOSE_CK + TRP_CK) ? AP_ACT_SUM : CLOSE_CK + TRP_CK;
  localparam logic [CW-1:0] AP_ACT_LD = CW'(AP_ACT_CK - 1);
  localparam logic [CW-1:0] RAS_LD = CW'(TRAS_CK - 1);
  localparam logic [CW-1:0] RD_LD = CW'(HALF - 1);
  localparam logic [CW-1:0] WR_LD = CW'(HALF + `DDRAP_WR_EXTRA - 1);

  logic [CW-1:0] rd_gap_ff; // to next read allowed
  logic [CW-1:0] wr_gap_ff; // to next write allowed
  logic [NBANK-1:0] act_ok; // per bank activate allowed
  logic [NBANK-1:0] pre_ok; // per bank explicit precharge allowed
  logic allow;
  logic take;
  logic ap_read;

  // ***************************************************************
  // acceptance
  // ***************************************************************
  // pre and act to another bank need only one clock, which one command
  // per clock already gives
  always_comb begin
    case (req_cmd)
      ddrap_pkg::DDRAP_ACT: allow = act_ok[req_ba];
      ddrap_pkg::DDRAP_RD: allow = (rd_gap_ff == '0);
      ddrap_pkg::DDRAP_WR: allow = (wr_gap_ff == '0);
      ddrap_pkg::DDRAP_PRE: allow = pre_ok[req_ba];
      default: allow = 1'b1;
    endcase
  end

  assign req_ready = ce && allow;
  assign take = req_valid && req_ready;
  assign ap_read = take && (req_cmd == ddrap_pkg::DDRAP_RD) && req_a10;

  // command register toward the device
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      link.cmd <= ddrap_pkg::DDRAP_NOP;
      link.ba <= '0;
      link.a10 <= 1'b0;
    end else if (ce) begin
      link.cmd <= take ? req_cmd : ddrap_pkg::DDRAP_NOP;
      link.ba <= take ? req_ba : link.ba;
      link.a10 <= take ? req_a10 : 1'b0;
    end
  end

  // ***************************************************************
  // spacing after a read with auto precharge
  // ***************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_gap_ff <= '0;
      wr_gap_ff <= '0;
    end else if (ce) begin
      if (ap_read) begin
        rd_gap_ff <= RD_LD;
        wr_gap_ff <= WR_LD;
      end else begin
        if (rd_gap_ff != '0) begin
          rd_gap_ff <= rd_gap_ff - 1'b1;
        end
        if (wr_gap_ff != '0) begin
          wr_gap_ff <= wr_gap_ff - 1'b1;
        end
      end
    end
  end

  // per-bank activate and precharge waits
  for (genvar b = 0; b < NBANK; b++) begin : g_bank
    logic hit;
    logic [CW-1:0] act_wait_ff; // to activate after auto close
    logic [CW-1:0] ras_wait_ff; // to tras met after activate

    assign hit = take && (req_ba == `DDRAP_BA_W'(b));
    assign act_ok[b] = (act_wait_ff == '0);
    assign pre_ok[b] = (ras_wait_ff == '0);

    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        act_wait_ff <= '0;
        ras_wait_ff <= '0;
      end else if (ce) begin
        if (hit && ap_read) begin
          act_wait_ff <= AP_ACT_LD;
        end else if (act_wait_ff != '0) begin
          act_wait_ff <= act_wait_ff - 1'b1;
        end
        if (hit && req_cmd == ddrap_pkg::DDRAP_ACT) begin
          ras_wait_ff <= RAS_LD;
        end else if (ras_wait_ff != '0) begin
          ras_wait_ff <= ras_wait_ff - 1'b1;
        end
      end
    end
  end

  // ***************************************************************
  // read data capture
  // ***************************************************************
  // rising element in the low half, falling element in the high half
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_valid <= 1'b0;
      rd_data <= '0;
    end else if (ce) begin
      rd_valid <= !link.dq_oe_n;
      rd_data <= {link.dq_fall, link.dq_rise};
    end
  end
endmodule : ddrap_ctl

// *** test/ddrap_link_asserts.sv ***
// checker for the read auto-precharge link between controller and device ends
// assumes it sits beside the link interface, one clock, ce held high
`timescale 1ns/1ps
`include "ddrap_defines.svh"

module ddrap_link_asserts #(
  parameter int AL = `DDRAP_AL,
  parameter int CL = `DDRAP_CL,
  parameter int BL = `DDRAP_BL,
  parameter int NBANK = `DDRAP_NBANK
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire ddrap_pkg::ddrap_cmd_t cmd,
  input wire logic [`DDRAP_BA_W-1:0] ba,
  input wire logic a10,
  input wire logic [`DDRAP_DQ_W-1:0] dq_rise,
  input wire logic [`DDRAP_DQ_W-1:0] dq_fall,
  input wire logic dq_oe_n,
  input wire logic ldqs,
  input wire logic ldqs_oe_n,
  input wire logic udqs,
  input wire logic udqs_oe_n,
  input wire logic [NBANK-1:0] bank_open,
  input wire logic [NBANK-1:0] bank_prech
);
  // ***************************************************************
  // helpers
  // ***************************************************************
  localparam int RL = AL + CL; // read latency
  localparam int RL1 = RL + 1; // one edge of slack for output register
  localparam int APF = AL + BL / 2; // scheduled close edge
  localparam int APL = APF + 1; // close may show one edge later
  logic rd_ap; // read with automatic close on the link
  assign rd_ap = (cmd == ddrap_pkg::DDRAP_RD) && a10;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // ***************************************************************
  // data path
  // ***************************************************************
  property p_rd_lat;
    (cmd == ddrap_pkg::DDRAP_RD) |-> ##[RL:RL1] !dq_oe_n;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read data not driven at read latency");
  property p_burst;
    $fell(dq_oe_n) |-> !dq_oe_n [*2];
  endproperty
  a_burst: assert property (p_burst) else $error("burst shorter than two beats");
  // both strobes follow the data enable, each owning one byte lane
  property p_strobe;
    (ldqs_oe_n == dq_oe_n) && (udqs_oe_n == dq_oe_n) && (ldqs == !dq_oe_n) && (udqs == !dq_oe_n);
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe lanes disagree with data");

  // ***************************************************************
  // controller spacing after a closing read
  // ***************************************************************
  property p_rd_gap;
    rd_ap |=> cmd != ddrap_pkg::DDRAP_RD;
  endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("read too soon after closing read");
  property p_wr_gap;
    rd_ap |=> (cmd != ddrap_pkg::DDRAP_WR) [*3];
  endproperty
  a_wr_gap: assert property (p_wr_gap) else $error("write too soon after closing read");

  // ***************************************************************
  // per-bank scheduling, each bank on its own
  // ***************************************************************
  property p_act_gap(b);
    (rd_ap && ba == b) |=> !(cmd == ddrap_pkg::DDRAP_ACT && ba == b) [*3];
  endproperty
  property p_ap_close(b);
    (rd_ap && ba == b) |-> ##[APF:APL] bank_prech[b];
  endproperty
  property p_no_early(b);
    (rd_ap && ba == b) |=> !bank_prech[b] [*3];
  endproperty
  property p_prech_len(b);
    $rose(bank_prech[b]) |-> !bank_open[b] ##1 !bank_prech[b];
  endproperty
  property p_keep_open(b);
    (cmd == ddrap_pkg::DDRAP_RD && !a10 && ba == b && bank_open[b]) |=> bank_open[b] [*3];
  endproperty
  property p_act_open(b);
    (cmd == ddrap_pkg::DDRAP_ACT && ba == b) |=> bank_open[b];
  endproperty
  for (genvar g = 0; g < NBANK; g++) begin : gen_bank
    a_act_gap: assert property (p_act_gap(g)) else $error("activate too soon after closing read");
    a_ap_close: assert property (p_ap_close(g)) else $error("automatic close missing");
    a_no_early: assert property (p_no_early(g)) else $error("automatic close too early");
    a_prech_len: assert property (p_prech_len(g)) else $error("precharge period wrong");
    a_keep_open: assert property (p_keep_open(g)) else $error("plain read closed the row");
    a_act_open: assert property (p_act_open(g)) else $error("activate ignored");
  end

  c_ap_act: cover property (rd_ap ##4 cmd == ddrap_pkg::DDRAP_ACT);
  c_burst: cover property ($fell(dq_oe_n) ##1 dq_rise != dq_fall);
  c_prech: cover property (bank_prech != '0);
endmodule : ddrap_link_asserts

// *** test/ddr2_read_auto_precharge_tb.sv ***
// testbench joining controller and device ends across the link
// assumes design files and checker compiled first; ce held high throughout
`timescale 1ns/1ps
`include "ddrap_defines.svh"

module ddr2_read_auto_precharge_tb;
  localparam int RL = `DDRAP_AL + `DDRAP_CL; // read latency
  localparam int BEATS = `DDRAP_BL / 2; // beats per burst
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1; // freeze is not exercised
  logic req_valid = 1'b0;
  logic req_ready;
  ddrap_pkg::ddrap_cmd_t req_cmd = ddrap_pkg::DDRAP_NOP;
  logic [`DDRAP_BA_W-1:0] req_ba = 3'h0;
  logic req_a10 = 1'b0;
  logic rd_valid;
  logic [2*`DDRAP_DQ_W-1:0] rd_data;
  logic [2*`DDRAP_DQ_W-1:0] fill_data = 32'h0;
  logic fill_valid = 1'b0;
  logic fill_ready;
  logic [`DDRAP_NBANK-1:0] bank_open;
  logic [`DDRAP_NBANK-1:0] bank_prech;
  logic underrun;
  logic [31:0] got_q[$]; // words returned to the controller user
  int failures = 0;
  int compares = 0;
  int n_under = 0; // beats sent with an empty fifo
  int i;

  always #25 clk = ~clk;

  // ***************************************************************
  // the two ends and the checker
  // ***************************************************************
  ddrap_if i_ddrap_if ();
  ddrap_ctl i_ddrap_ctl (.clk(clk), .arst_n(arst_n), .ce(ce), .link(i_ddrap_if), .req_valid(req_valid),
    .req_ready(req_ready), .req_cmd(req_cmd), .req_ba(req_ba), .req_a10(req_a10), .rd_valid(rd_valid),
    .rd_data(rd_data));
  ddrap_dev i_ddrap_dev (.clk(clk), .arst_n(arst_n), .ce(ce), .link(i_ddrap_if), .fill_data(fill_data),
    .fill_valid(fill_valid), .fill_ready(fill_ready), .bank_open(bank_open), .bank_prech(bank_prech),
    .underrun(underrun));
  ddrap_link_asserts i_ddrap_link_asserts (.clk(clk), .arst_n(arst_n), .cmd(i_ddrap_if.cmd),
    .ba(i_ddrap_if.ba), .a10(i_ddrap_if.a10), .dq_rise(i_ddrap_if.dq_rise), .dq_fall(i_ddrap_if.dq_fall),
    .dq_oe_n(i_ddrap_if.dq_oe_n), .ldqs(i_ddrap_if.ldqs), .ldqs_oe_n(i_ddrap_if.ldqs_oe_n),
    .udqs(i_ddrap_if.udqs), .udqs_oe_n(i_ddrap_if.udqs_oe_n), .bank_open(bank_open), .bank_prech(bank_prech));

  // collect returned words and underrun beats
  always @(posedge clk) begin
    if (rd_valid === 1'b1) got_q.push_back(rd_data);
    if (underrun === 1'b1) n_under++;
  end

  // ***************************************************************
  // tasks
  // ***************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  // fill pattern, distinct in every byte lane
  function automatic logic [31:0] word(input int k);
    return 32'h13579bdf ^ 32'(k * 32'h01010101);
  endfunction : word

  // one request from a rising edge; compares how long it was held back
  task automatic req(input ddrap_pkg::ddrap_cmd_t c, input int b, input logic a, input int exp_wait);
    int n;
    req_valid <= 1'b1;
    req_cmd <= c;
    req_ba <= 3'(b);
    req_a10 <= a;
    n = 0;
    @(negedge clk);
    while (req_ready !== 1'b1 && n < 20) begin
      n++;
      @(negedge clk);
    end
    if (n == 20) begin
      failures++;
      conclude();
    end
    @(posedge clk);
    check(32'(n), 32'(exp_wait));
  endtask : req

  // release the request lines for some cycles
  task automatic idle(input int n);
    req_valid <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : idle

  // one word into the device fifo, bounded wait for room
  task automatic push(input logic [31:0] w);
    int n;
    fill_valid <= 1'b1;
    fill_data <= w;
    n = 0;
    @(negedge clk);
    while (fill_ready !== 1'b1 && n < 20) begin
      n++;
      @(negedge clk);
    end
    if (n == 20) begin
      failures++;
      conclude();
    end
    @(posedge clk);
  endtask : push

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    check(32'(bank_open), 32'h0);
    check(32'(bank_prech), 32'h0);
    check(32'({i_ddrap_if.dq_oe_n, fill_ready}), 32'h3);
    @(posedge clk);
    // fill the fifo until it refuses
    for (i = 0; i < 16; i++) push(word(i));
    fill_valid <= 1'b0;
    @(negedge clk);
    check(32'(fill_ready), 32'h0);
    @(posedge clk);
    for (i = 0; i < 4; i++) req(ddrap_pkg::DDRAP_ACT, i, 1'b0, 0);
    // same-bank activate held back after a closing read
    req(ddrap_pkg::DDRAP_RD, 0, 1'b1, 0);
    // close lands al+bl/2 after the read, then one precharge clock
    req(ddrap_pkg::DDRAP_ACT, 0, 1'b0, 3);
    idle(6);
    // reads and writes to other banks held back
    req(ddrap_pkg::DDRAP_RD, 1, 1'b1, 0);
    req(ddrap_pkg::DDRAP_RD, 2, 1'b0, 1);
    req(ddrap_pkg::DDRAP_WR, 2, 1'b0, 1);
    idle(6);
    // activate another bank while a close is pending
    req(ddrap_pkg::DDRAP_RD, 3, 1'b1, 0);
    req(ddrap_pkg::DDRAP_ACT, 4, 1'b0, 0);
    for (i = 0; i < 4; i++) begin
      req(ddrap_pkg::DDRAP_RD, 2, 1'b0, 0);
      idle(3);
    end
    check(32'(bank_open), 32'h15);
    // fifo now empty: one more read sends zeros
    req(ddrap_pkg::DDRAP_RD, 2, 1'b0, 0);
    idle(RL + BEATS + 3);
    check(32'(got_q.size()), 32'd18);
    for (i = 0; i < 16; i++) check(got_q[i], word(i));
    check(got_q[16], 32'h0);
    check(got_q[17], 32'h0);
    check(32'(n_under), 32'(BEATS));
    // explicit precharge right after activate
    req(ddrap_pkg::DDRAP_ACT, 6, 1'b0, 0);
    req(ddrap_pkg::DDRAP_PRE, 6, 1'b0, 0);
    idle(3);
    check(32'(bank_open[6]), 32'h0);
    conclude();
  end
endmodule : ddr2_read_auto_precharge_tb
